// File: design/scs_pkg.sv
// constants, field layouts and enumerations for the system clock source select block
// assumes a single 10 MHz reference clock and an apb register port in the top module

package scs_pkg;

    // -----------------------------------------------------------------
    // timing
    // -----------------------------------------------------------------
    localparam int unsigned CLK_HZ = 10_000_000;
    localparam int unsigned LOCK_WAIT_MS = 2;
    localparam int unsigned LOCK_WAIT_CYC = LOCK_WAIT_MS * (CLK_HZ / 1000);
    localparam int unsigned OSC_SETTLE_EDGES = 1024;
    localparam int unsigned SYNC_EDGES = 8;
    localparam logic [2:0] PLL_MULT = 3'h4;
    localparam logic [1:0] Q_LAST = 2'h3;

    // -----------------------------------------------------------------
    // register map
    // -----------------------------------------------------------------
    localparam logic [7:0] CTRL_OFS = 8'h00;
    localparam logic [7:0] STAT_OFS = 8'h04;
    localparam int unsigned SCS_BIT = 0;
    localparam int unsigned ST_SRC_BIT = 0;
    localparam int unsigned ST_RUN_BIT = 1;
    localparam int unsigned ST_PLL_BIT = 2;
    localparam int unsigned ST_BUSY_BIT = 3;
    localparam int unsigned ST_MODE_LSB = 4;
    localparam logic [31:0] RD_ZERO = 32'h0000_0000;

    // -----------------------------------------------------------------
    // enumerations
    // -----------------------------------------------------------------
    typedef enum logic [2:0] {
        low_power_xtal = 3'h0,
        standard_crystal = 3'h1,
        high_speed_crystal = 3'h2,
        pll_times_four_crystal = 3'h3,
        resistor_capacitor_div_out = 3'h4,
        resistor_capacitor_gpio = 3'h5,
        ext_clock_div_out = 3'h6,
        ext_clock_gpio_mode = 3'h7
    } scs_mode_e;

    typedef enum logic [2:0] {
        ST_SETTLE = 3'h0,
        ST_LOCK = 3'h1,
        ST_SYNC_MAIN = 3'h3,
        ST_RUN_MAIN = 3'h2,
        ST_WAIT_Q1 = 3'h6,
        ST_SYNC_SEC = 3'h7,
        ST_RUN_SEC = 3'h5
    } scs_state_e;

endpackage

// File: design/scs_pin_sync.sv
// three-stage synchronisers for asynchronous pin levels, one per bit
// assumes pins change slower than two reference clock periods
`timescale 1ns/10ps

module scs_pin_sync
    import scs_pkg::*;
#(
    parameter int unsigned WIDTH = 1
)
(
    // clock and reset
    input wire logic ref_clk,
    input wire logic sys_rst,
    // raw pins
    input wire logic [WIDTH-1:0] pin_raw,
    // filtered level and rising-edge pulse
    output logic [WIDTH-1:0] pin_lvl,
    output logic [WIDTH-1:0] pin_rise
);

    // -----------------------------------------------------------------
    // start-up fill
    // -----------------------------------------------------------------
    logic [2:0] fill_r, fill_nxt;
    logic primed;

    // edges stay masked until the stages hold real samples, so the reset
    // level cannot pose as a rising edge of a pin that starts high
    always_comb
    begin
        fill_nxt = {fill_r[1:0], 1'b1};
    end
    assign primed = fill_r[2];

    // fill marker, one stage per synchroniser flop
    always_ff @(posedge ref_clk or posedge sys_rst)
    begin
        if (sys_rst)
            fill_r <= 3'h0;
        else
            fill_r <= fill_nxt;
    end

    // -----------------------------------------------------------------
    // per-bit filter
    // -----------------------------------------------------------------
    genvar gi;
    generate
        for (gi = 0; gi < WIDTH; gi++)
        begin : g_bit
            logic s1_r, s2_r, s3_r, lvl_r, rise_r;
            logic lvl_nxt, rise_nxt;
            // level only moves once stages two and three agree; while filling it
            // just copies stage two so that no edge is invented
            always_comb
            begin
                lvl_nxt = primed ? ((s2_r == s3_r) ? s3_r : lvl_r) : s2_r;
                rise_nxt = primed & lvl_nxt & ~lvl_r;
            end
            always_ff @(posedge ref_clk or posedge sys_rst)
            begin
                if (sys_rst)
                begin
                    s1_r <= 1'b0;
                    s2_r <= 1'b0;
                    s3_r <= 1'b0;
                    lvl_r <= 1'b0;
                    rise_r <= 1'b0;
                end
                else
                begin
                    s1_r <= pin_raw[gi];
                    s2_r <= s1_r;
                    s3_r <= s2_r;
                    lvl_r <= lvl_nxt;
                    rise_r <= rise_nxt;
                end
            end
            assign pin_lvl[gi] = lvl_r;
            assign pin_rise[gi] = rise_r;
        end
    endgenerate

endmodule

// File: design/scs_event_cnt.sv
// saturating event counter with a clear and a compare against a target
// assumes the caller clears it on every state change
`timescale 1ns/10ps

module scs_event_cnt
    import scs_pkg::*;
#(
    parameter int unsigned W = 16
)
(
    // clock and reset
    input wire logic ref_clk,
    input wire logic sys_rst,
    // control
    input wire logic cnt_clr,
    input wire logic cnt_inc,
    input wire logic [W-1:0] cnt_target,
    // result
    output logic [W-1:0] cnt_val,
    output logic cnt_done
);

    logic [W-1:0] cnt_r, cnt_nxt;

    // -----------------------------------------------------------------
    // count, stop at target so the compare holds
    // -----------------------------------------------------------------
    always_comb
    begin
        cnt_nxt = cnt_r;
        if (cnt_clr)
            cnt_nxt = '0;
        else if (cnt_inc && (cnt_r < cnt_target))
            cnt_nxt = cnt_r + W'(1);
    end

    always_ff @(posedge ref_clk or posedge sys_rst)
    begin
        if (sys_rst)
            cnt_r <= '0;
        else
            cnt_r <= cnt_nxt;
    end

    assign cnt_val = cnt_r;
    assign cnt_done = (cnt_r >= cnt_target);

endmodule

// File: design/scs_top.sv
// system clock source select: mode straps, divided output pin, pll lock wait,
// glitch-free switch between main and secondary oscillator, apb register port
// assumes oscillator pins are slow against ref_clk; clocks leave as tick enables
`timescale 1ns/10ps

module scs_top
    import scs_pkg::*;
#(
    parameter int unsigned LOCK_CYCLES = LOCK_WAIT_CYC,
    parameter int unsigned SETTLE_EDGES = OSC_SETTLE_EDGES,
    parameter int unsigned CNT_W = 16
)
(
    // clock and reset
    input wire logic ref_clk,
    input wire logic sys_rst,
    // programmed configuration
    input wire logic [2:0] osc_mode_cfg,
    input wire logic clock_switch_enable_n,
    input wire logic secondary_osc_enable,
    // oscillator pins
    input wire logic osc_in_pin,
    input wire logic sec_osc_pin,
    input wire logic osc_out_i,
    output logic osc_out_o,
    output logic osc_out_oe,
    // first_gpio_port_bit6 when the output pin is free
    input wire logic gpio6_out,
    input wire logic gpio6_oe,
    output logic gpio6_in,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // core clocking
    output logic sys_clk_tick,
    output logic [1:0] q_phase,
    output logic cpu_run,
    output logic pll_enable,
    output logic src_is_secondary
);

    // -----------------------------------------------------------------
    // elaboration checks
    // -----------------------------------------------------------------
    generate
        if (LOCK_CYCLES >= (2 ** CNT_W) || SETTLE_EDGES >= (2 ** CNT_W) || LOCK_CYCLES < 1)
        begin : g_bad_cnt
            $error("counter too narrow for lock or settle count");
        end
    endgenerate

    // -----------------------------------------------------------------
    // pin synchronisers
    // -----------------------------------------------------------------
    logic [2:0] pin_lvl, pin_rise;
    logic main_edge, sec_tick;

    scs_pin_sync #(.WIDTH(3)) u_sync (
        .ref_clk(ref_clk),
        .sys_rst(sys_rst),
        .pin_raw({osc_out_i, sec_osc_pin, osc_in_pin}),
        .pin_lvl(pin_lvl),
        .pin_rise(pin_rise)
    );
    assign main_edge = pin_rise[0];
    assign sec_tick = pin_rise[1];
    assign gpio6_in = pin_lvl[2]; // already a flop in the synchroniser

    // -----------------------------------------------------------------
    // configuration capture, once after reset release
    // -----------------------------------------------------------------
    scs_mode_e mode_r, mode_nxt;
    logic cfg_valid_r, cfg_valid_nxt, sw_en_n_r, sw_en_n_nxt;

    // straps are sampled by a clock, never loaded by the reset itself
    always_comb
    begin
        mode_nxt = mode_r;
        sw_en_n_nxt = sw_en_n_r;
        cfg_valid_nxt = 1'b1;
        if (!cfg_valid_r)
        begin
            mode_nxt = scs_mode_e'(osc_mode_cfg);
            sw_en_n_nxt = clock_switch_enable_n;
        end
    end

    always_ff @(posedge ref_clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            mode_r <= low_power_xtal;
            sw_en_n_r <= 1'b1; // erased value keeps switching off
            cfg_valid_r <= 1'b0;
        end
        else
        begin
            mode_r <= mode_nxt;
            sw_en_n_r <= sw_en_n_nxt;
            cfg_valid_r <= cfg_valid_nxt;
        end
    end

    logic is_crystal, is_pll, is_div_out, is_gpio;
    always_comb
    begin
        is_pll = (mode_r == pll_times_four_crystal);
        is_crystal = (mode_r == low_power_xtal) || (mode_r == standard_crystal)
            || (mode_r == high_speed_crystal) || is_pll;
        is_div_out = (mode_r == resistor_capacitor_div_out) || (mode_r == ext_clock_div_out);
        is_gpio = (mode_r == resistor_capacitor_gpio) || (mode_r == ext_clock_gpio_mode);
    end

    // -----------------------------------------------------------------
    // pll model and main tick
    // -----------------------------------------------------------------
    logic [2:0] burst_r, burst_nxt;
    logic pll_en_r, pll_en_nxt, main_tick;

    // each input edge spawns four ticks; input edges must be at least four cycles apart
    always_comb
    begin
        pll_en_nxt = cfg_valid_r && is_pll;
        burst_nxt = burst_r;
        if (pll_en_r && main_edge)
            burst_nxt = PLL_MULT;
        else if (burst_r != 3'h0)
            burst_nxt = burst_r - 3'h1;
    end
    // pll output replaces the raw edge on the switch input
    assign main_tick = pll_en_r ? (burst_r != 3'h0) : main_edge;

    always_ff @(posedge ref_clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            burst_r <= 3'h0;
            pll_en_r <= 1'b0;
        end
        else
        begin
            burst_r <= burst_nxt;
            pll_en_r <= pll_en_nxt;
        end
    end

    // -----------------------------------------------------------------
    // control register and apb slave
    // -----------------------------------------------------------------
    logic scs_r, scs_nxt, sw_allowed, ap_setup, ap_write;
    logic [31:0] prdata_nxt;
    logic pready_nxt, pslverr_nxt;
    scs_state_e state_r, state_nxt;
    logic src_sec_r, src_sec_nxt, run_r, run_nxt;

    assign sw_allowed = !sw_en_n_r && cfg_valid_r && secondary_osc_enable;
    assign ap_setup = psel && !penable;
    assign ap_write = psel && penable && pready && pwrite;

    // zero-wait slave: read data is prepared in the setup cycle
    always_comb
    begin
        scs_nxt = scs_r;
        if (!sw_allowed)
            scs_nxt = 1'b0;
        else if (ap_write && paddr == CTRL_OFS)
            scs_nxt = pwdata[SCS_BIT];
        pready_nxt = ap_setup;
        pslverr_nxt = ap_setup && (paddr != CTRL_OFS) && (paddr != STAT_OFS);
        prdata_nxt = RD_ZERO;
        if (ap_setup && !pwrite && paddr == CTRL_OFS)
            prdata_nxt[SCS_BIT] = scs_r;
        else if (ap_setup && !pwrite && paddr == STAT_OFS)
        begin
            prdata_nxt[ST_SRC_BIT] = src_sec_r;
            prdata_nxt[ST_RUN_BIT] = run_r;
            prdata_nxt[ST_PLL_BIT] = pll_en_r;
            prdata_nxt[ST_BUSY_BIT] = !run_r;
            prdata_nxt[ST_MODE_LSB +: 3] = mode_r;
        end
    end

    always_ff @(posedge ref_clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            scs_r <= 1'b0;
            prdata <= RD_ZERO;
            pready <= 1'b0;
            pslverr <= 1'b0;
        end
        else
        begin
            scs_r <= scs_nxt;
            prdata <= prdata_nxt;
            pready <= pready_nxt;
            pslverr <= pslverr_nxt;
        end
    end

    // -----------------------------------------------------------------
    // switch sequencer
    // -----------------------------------------------------------------
    logic cnt_inc, cnt_done;
    logic [CNT_W-1:0] cnt_target, cnt_val;
    logic [1:0] qph_r, qph_nxt;
    logic tick_nxt, tick_r, src_tick;

    assign src_tick = src_sec_r ? sec_tick : main_tick;

    // what the counter watches depends on the wait in progress
    always_comb
    begin
        cnt_inc = 1'b0;
        cnt_target = CNT_W'(SYNC_EDGES);
        unique case (state_r)
            ST_SETTLE:
            begin
                cnt_inc = main_edge;
                cnt_target = CNT_W'(SETTLE_EDGES);
            end
            ST_LOCK:
            begin
                cnt_inc = 1'b1;
                cnt_target = CNT_W'(LOCK_CYCLES);
            end
            ST_SYNC_MAIN: cnt_inc = main_edge;
            ST_SYNC_SEC: cnt_inc = sec_tick;
            default: cnt_inc = 1'b0;
        endcase
    end

    scs_event_cnt #(.W(CNT_W)) u_cnt (
        .ref_clk(ref_clk),
        .sys_rst(sys_rst),
        .cnt_clr(state_r != state_nxt),
        .cnt_inc(cnt_inc),
        .cnt_target(cnt_target),
        .cnt_val(cnt_val),
        .cnt_done(cnt_done)
    );

    // source changes only while frozen, so no short tick can escape
    always_comb
    begin
        state_nxt = state_r;
        src_sec_nxt = src_sec_r;
        unique case (state_r)
            ST_SETTLE:
                if (cfg_valid_r && (!is_crystal || cnt_done))
                    state_nxt = is_pll ? ST_LOCK : ST_SYNC_MAIN;
            ST_LOCK:
                if (cnt_done)
                    state_nxt = ST_SYNC_MAIN;
            ST_SYNC_MAIN:
                if (cnt_done)
                    state_nxt = ST_RUN_MAIN;
            ST_RUN_MAIN:
                if (scs_r)
                    state_nxt = ST_WAIT_Q1;
            ST_WAIT_Q1:
                if (!scs_r)
                    state_nxt = ST_RUN_MAIN;
                else if (main_tick && qph_r == Q_LAST)
                    state_nxt = ST_SYNC_SEC;
            ST_SYNC_SEC:
                if (cnt_done)
                begin
                    state_nxt = ST_RUN_SEC;
                    src_sec_nxt = 1'b1;
                end
            ST_RUN_SEC:
                if (!scs_r)
                begin
                    state_nxt = ST_SETTLE;
                    src_sec_nxt = 1'b0;
                end
            default:
            begin
                state_nxt = ST_SETTLE;
                src_sec_nxt = 1'b0;
            end
        endcase
        run_nxt = (state_nxt == ST_RUN_MAIN) || (state_nxt == ST_RUN_SEC)
            || (state_nxt == ST_WAIT_Q1);
        tick_nxt = run_r && src_tick;
        qph_nxt = tick_nxt ? qph_r + 2'h1 : qph_r;
    end

    always_ff @(posedge ref_clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            state_r <= ST_SETTLE;
            src_sec_r <= 1'b0;
            run_r <= 1'b0;
            tick_r <= 1'b0;
            qph_r <= 2'h0;
        end
        else
        begin
            state_r <= state_nxt;
            src_sec_r <= src_sec_nxt;
            run_r <= run_nxt;
            tick_r <= tick_nxt;
            qph_r <= qph_nxt;
        end
    end

    assign sys_clk_tick = tick_r;
    assign q_phase = qph_r;
    assign cpu_run = run_r;
    assign pll_enable = pll_en_r;
    assign src_is_secondary = src_sec_r;

    // -----------------------------------------------------------------
    // output pin: divide by four or gpio
    // -----------------------------------------------------------------
    logic [1:0] div_r, div_nxt;
    logic oo_r, oo_nxt, oe_r, oe_nxt;

    // crystal modes leave the pin to the analog feedback inverter
    always_comb
    begin
        div_nxt = main_edge ? div_r + 2'h1 : div_r;
        oo_nxt = 1'b0;
        oe_nxt = 1'b0;
        if (cfg_valid_r && is_div_out)
        begin
            oo_nxt = div_r[1];
            oe_nxt = 1'b1;
        end
        else if (cfg_valid_r && is_gpio)
        begin
            oo_nxt = gpio6_out;
            oe_nxt = gpio6_oe;
        end
    end

    always_ff @(posedge ref_clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            div_r <= 2'h0;
            oo_r <= 1'b0;
            oe_r <= 1'b0;
        end
        else
        begin
            div_r <= div_nxt;
            oo_r <= oo_nxt;
            oe_r <= oe_nxt;
        end
    end

    assign osc_out_o = oo_r;
    assign osc_out_oe = oe_r;

    // -----------------------------------------------------------------
    // assertions
    // -----------------------------------------------------------------
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (sys_rst);

    AST_SCS_FORCED_CLEAR: assert property (!sw_allowed |=> !scs_r)
        else $error("switch bit set without both enables");
    AST_CTRL_UPPER_ZERO: assert property (ap_setup && !pwrite && paddr == CTRL_OFS
        |=> prdata[31:1] == 31'h0 && prdata[0] == $past(scs_r))
        else $error("control read returned wrong bits");
    AST_PLL_MODE_ONLY: assert property (pll_enable |-> mode_r == pll_times_four_crystal)
        else $error("pll enabled outside pll mode");
    AST_LOCK_HOLDS_CPU: assert property (state_r == ST_LOCK |=> !cpu_run)
        else $error("cpu ran during pll lock wait");
    AST_EXT_NO_WAIT: assert property (state_r == ST_SETTLE && cfg_valid_r && !is_crystal
        |=> state_r == ST_SYNC_MAIN)
        else $error("start-up wait applied in non-crystal mode");
    AST_SEC_AFTER_EIGHT: assert property ($rose(src_sec_r)
        |-> $past(state_r) == ST_SYNC_SEC && $past(cnt_val) == CNT_W'(SYNC_EDGES))
        else $error("secondary selected before eight edges");
    AST_FREEZE_AT_Q1: assert property (state_r == ST_SYNC_SEC
        |-> qph_r == 2'h0 ##1 !tick_r)
        else $error("freeze not at first quarter");
    AST_SETTLE_DONE: assert property (state_r == ST_SETTLE && is_crystal
        && state_nxt != ST_SETTLE |-> cnt_val == CNT_W'(SETTLE_EDGES))
        else $error("crystal settle cut short");
    AST_MAIN_EIGHT: assert property (state_r == ST_SYNC_MAIN ##1 state_r == ST_RUN_MAIN
        |-> $past(cnt_val) == CNT_W'(SYNC_EDGES))
        else $error("main resumed before eight edges");
    AST_PLL_FOUR: assert property (pll_en_r && main_edge && burst_r == 3'h0
        |=> main_tick [*4] ##1 !main_tick)
        else $error("pll did not give four ticks");
    AST_DIV_STABLE: assert property (cfg_valid_r && is_div_out && !$past(main_edge, 2)
        && $past(cfg_valid_r, 2) |-> $stable(osc_out_o))
        else $error("divided output moved without an oscillator edge");

    COV_TO_SEC: cover property (state_r == ST_SYNC_SEC ##1 state_r == ST_RUN_SEC);
    COV_BACK_MAIN: cover property (state_r == ST_RUN_SEC ##1 state_r == ST_SETTLE);
    COV_LOCK_DONE: cover property (state_r == ST_LOCK ##1 state_r == ST_SYNC_MAIN);

endmodule

// File: verif/scs_osc_model.sv
// oscillator partner: main clock source on the input pin and the secondary oscillator
// assumes the output pin has no pull, so an undriven pin shows a changing level
`timescale 1ns/10ps

module scs_osc_model #(
    parameter int MAIN_HALF = 500,
    parameter int SEC_HALF = 1507
)
(
    // oscillator pins
    output logic osc_in_pin,
    output logic sec_osc_pin,
    // output pin as driven and as read back
    input wire logic osc_out_o,
    input wire logic osc_out_oe,
    output logic osc_out_i
);
    // ----------------------------------------------------------------
    // free-running sources; the main one keeps its edges on reference clock falling edges, the secondary drifts
    // ----------------------------------------------------------------
    initial
    begin
        osc_in_pin = 1'b0;
        forever #(MAIN_HALF) osc_in_pin = ~osc_in_pin;
    end

    // secondary period is not a multiple of the main one, on purpose
    initial
    begin
        sec_osc_pin = 1'b0;
        forever #(SEC_HALF) sec_osc_pin = ~sec_osc_pin;
    end

    // released pin follows a toggling source so a stale level cannot pass
    always_comb osc_out_i = osc_out_oe ? osc_out_o : osc_in_pin;
endmodule

// File: verif/system_clock_source_select_bench.sv
// testbench: mode sweep, switching to and from the secondary source, apb refusals
// assumes the partner model drives both oscillator pins
`timescale 1ns/10ps

module system_clock_source_select_bench;
    import scs_pkg::*;
    logic ref_clk, sys_rst, clock_switch_enable_n, secondary_osc_enable, osc_in_pin;
    logic sec_osc_pin, osc_out_i, osc_out_o, osc_out_oe, gpio6_out, gpio6_oe, gpio6_in;
    logic psel, penable, pwrite, pready, pslverr, erro, p;
    logic sys_clk_tick, cpu_run, pll_enable, src_is_secondary;
    logic [2:0] osc_mode_cfg;
    logic [1:0] q_phase;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    int err_count = 0;
    int samples_checked = 0;
    int n, r;

    // short lock and settle counts keep the run brief
    scs_top #(.LOCK_CYCLES(40), .SETTLE_EDGES(16)) u_dut (.ref_clk(ref_clk),
        .sys_rst(sys_rst), .osc_mode_cfg(osc_mode_cfg),
        .clock_switch_enable_n(clock_switch_enable_n),
        .secondary_osc_enable(secondary_osc_enable), .osc_in_pin(osc_in_pin),
        .sec_osc_pin(sec_osc_pin), .osc_out_i(osc_out_i), .osc_out_o(osc_out_o),
        .osc_out_oe(osc_out_oe), .gpio6_out(gpio6_out), .gpio6_oe(gpio6_oe),
        .gpio6_in(gpio6_in), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .sys_clk_tick(sys_clk_tick), .q_phase(q_phase),
        .cpu_run(cpu_run), .pll_enable(pll_enable), .src_is_secondary(src_is_secondary));
    scs_osc_model u_osc (.osc_in_pin(osc_in_pin), .sec_osc_pin(sec_osc_pin),
        .osc_out_o(osc_out_o), .osc_out_oe(osc_out_oe), .osc_out_i(osc_out_i));

    // ----------------------------------------------------------------
    // clock, compare and bus tasks
    // ----------------------------------------------------------------
    initial
    begin
        ref_clk = 1'b0;
        forever #50 ref_clk = ~ref_clk;
    end

    task automatic complete_run;
        if (err_count == 0 && samples_checked > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask

    task automatic chk32(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp)
        begin
            err_count++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic chk1(input logic got, input logic exp);
        chk32({31'h0, got}, {31'h0, exp});
    endtask

    // one apb transfer; read data and error are taken at the pready edge
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge ref_clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge ref_clk);
        penable <= 1'b1;
        // no cycle count assumed here; the watchdog ends a hung wait
        do
            @(posedge ref_clk);
        while (pready !== 1'b1);
        rd = prdata;
        erro = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic do_reset(input logic [2:0] m);
        osc_mode_cfg <= m;
        sys_rst <= 1'b1;
        repeat (5) @(posedge ref_clk);
        sys_rst <= 1'b0;
        repeat (2) @(posedge ref_clk);
    endtask

    // waits for the core to run from the given source; n holds the cycles taken
    task automatic wait_run(input logic src);
        n = 0;
        while (!(cpu_run === 1'b1 && src_is_secondary === src) && n < 3000)
        begin
            @(posedge ref_clk);
            n++;
        end
        chk1(src_is_secondary, src);
        chk1(cpu_run, 1'b1);
    endtask

    // ----------------------------------------------------------------
    // tests
    // ----------------------------------------------------------------
    initial
    begin
        sys_rst = 1'b1;
        osc_mode_cfg = 3'h0;
        clock_switch_enable_n = 1'b0;
        secondary_osc_enable = 1'b1;
        gpio6_out = 1'b1;
        gpio6_oe = 1'b1;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0000_0000;
        // every mode: start-up, pll, ticks per main edge, output pin use
        for (int m = 0; m < 8; m++)
        begin
            do_reset(3'(m));
            wait_run(1'b0);
            // start-up length: eight edges, settle plus eight, or settle, lock and eight
            r = (m == 3) ? 260 : (m < 3) ? 220 : 60;
            chk1(n >= r && n < r + 40, 1'b1);
            chk1(pll_enable, m == 3);
            apb(1'b0, STAT_OFS, 32'h0000_0000);
            chk32(rd & 32'h0000_0070, 32'(m) << ST_MODE_LSB);
            n = 0;
            r = 0;
            p = osc_out_o;
            // window of sixteen main periods, so straddled edges do not matter
            repeat (160)
            begin
                @(posedge ref_clk);
                n += int'(sys_clk_tick === 1'b1);
                r += int'(osc_out_o === 1'b1 && p === 1'b0);
                p = osc_out_o;
            end
            chk32(32'(n), (m == 3) ? 32'h0000_0040 : 32'h0000_0010);
            chk32(32'(r), (m == 4 || m == 6) ? 32'h0000_0004 : 32'h0000_0000);
            chk1(osc_out_oe, m >= 4);
            if (m == 5 || m == 7)
                chk1(gpio6_in, 1'b1);
        end
        // switch to secondary and back on a crystal main oscillator
        do_reset(3'h1);
        wait_run(1'b0);
        apb(1'b0, CTRL_OFS, 32'h0000_0000);
        chk32(rd, 32'h0000_0000);
        apb(1'b1, CTRL_OFS, 32'hFFFF_FFFF);
        apb(1'b0, CTRL_OFS, 32'h0000_0000);
        chk32(rd, 32'h0000_0001);
        n = 0;
        while (cpu_run !== 1'b0 && n < 200)
        begin
            @(posedge ref_clk);
            n++;
        end
        chk32({30'h0, q_phase}, 32'h0000_0000);
        chk1(cpu_run, 1'b0);
        wait_run(1'b1);
        apb(1'b1, CTRL_OFS, 32'h0000_0000);
        wait_run(1'b0);
        chk1(n > 160, 1'b1);
        apb(1'b0, 8'h08, 32'h0000_0000);
        chk1(erro, 1'b1);
        // secondary disabled: write dropped
        secondary_osc_enable <= 1'b0;
        apb(1'b1, CTRL_OFS, 32'h0000_0001);
        apb(1'b0, CTRL_OFS, 32'h0000_0000);
        chk32(rd, 32'h0000_0000);
        // reset in mid-run from secondary, then switching strap off
        secondary_osc_enable <= 1'b1;
        apb(1'b1, CTRL_OFS, 32'h0000_0001);
        wait_run(1'b1);
        clock_switch_enable_n <= 1'b1;
        do_reset(3'h6);
        wait_run(1'b0);
        apb(1'b1, CTRL_OFS, 32'h0000_0001);
        apb(1'b0, CTRL_OFS, 32'h0000_0000);
        chk32(rd, 32'h0000_0000);
        complete_run();
    end

    // hang guard, well past the expected run length
    initial
    begin
        repeat (60000) @(posedge ref_clk);
        err_count++;
        complete_run();
    end
endmodule
